// *** verilog/tpc_cfg.svh ***
// Constants for the three-phase PWM configuration block: register indexes,
// bit positions, reset values and bus response codes.
// Assumes a 32-bit AXI4-Lite slave with one register per aligned word.
`ifndef TPC_CFG_SVH
`define TPC_CFG_SVH

// Register indexes; byte address is four times the index
`define TPC_IDX_CTRL_ZERO 10'h308
`define TPC_IDX_CTRL_ONE 10'h309
`define TPC_IDX_PAT_ZERO 10'h30a
`define TPC_IDX_PAT_ONE 10'h30b
`define TPC_IDX_DEADTIME 10'h30c
`define TPC_IDX_DECIM 10'h30d
`define TPC_IDX_CARRIER 10'h334
`define TPC_IDX_SPECIAL 10'h33e

// Control zero fields
`define TPC_C0_COND_LOW 0
`define TPC_C0_COND_HIGH 1
`define TPC_C0_OUT_EN 3
`define TPC_C0_MOD_SEL 6
`define TPC_C0_SW_TRIG 7
`define TPC_C0_WMASK 8'h4b

// Control one fields
`define TPC_C1_START_SEL 0
`define TPC_C1_PHASE_MODE 1
`define TPC_C1_DT_CLK 2
`define TPC_C1_SLOPE 3
`define TPC_C1_ACT_LVL 4
`define TPC_C1_DT_DIS 5
`define TPC_C1_DT_TRIG 6
`define TPC_C1_WMASK 8'hf7

// Special mode fields
`define TPC_SM_RELOAD_TIMING 0
`define TPC_SM_CUTOFF_EN 1
`define TPC_SM_WMASK 8'h03

// Reset values
`define TPC_RST_REG8 8'h00
`define TPC_RST_PAT 6'h3f
`define TPC_RST_CAR 16'h0000

// AXI responses
`define TPC_RESP_OKAY 2'b00
`define TPC_RESP_SLVERR 2'b10

`endif

// *** verilog/tpc_pkg.sv ***
// Types of the three-phase PWM configuration block.
// Assumes tpc_cfg.svh is on the include path.
`include "tpc_cfg.svh"

package tpc_pkg;

    // Whole state of the block, registered as one word
    typedef struct packed {
        logic aw_held;
        logic [11:0] aw_addr;
        logic w_held;
        logic [31:0] w_data;
        logic [3:0] w_strb;
        logic b_valid;
        logic [1:0] b_resp;
        logic r_valid;
        logic [31:0] r_data;
        logic [1:0] r_resp;
        logic [7:0] ctrl_zero;
        logic [7:0] ctrl_one;
        logic [7:0] special;
        logic [7:0] deadtime_reload;
        logic [7:0] decim_count;
        logic [7:0] decim_value;
        logic [15:0] carrier;
        logic carrier_load;
        logic [5:0] pat_zero;
        logic [5:0] pat_one;
        logic [5:0] shift_zero;
        logic [5:0] shift_one;
        logic dirty;
        logic [2:0] use_second;
        logic [2:0] oneshot_d;
        logic [5:0] raw_d;
        logic [2:0][7:0] dt_count;
        logic [5:0] phase_int;
        logic [5:0] pin;
        logic dt_div;
        logic phase_start;
        logic carrier_reload;
        logic carrier_irq;
        logic sd_meta;
        logic sd_sync;
    } tpc_state_s;

endpackage

// *** verilog/tpc_pwm.sv ***
// Three-phase PWM configuration and output-pattern logic behind an
// AXI4-Lite register slave.
// Assumes the carrier timer and the three phase timers sit outside on the
// same clock and hand in their underflow, one-shot and reload signals.
`timescale 1ns/10ps
`default_nettype none
`include "tpc_cfg.svh"

module tpc_pwm (
    input wire logic clk,
    input wire logic rst_n,
    // AXI4-Lite slave
    input wire logic [11:0] s_axi_awaddr,
    input wire logic s_axi_awvalid,
    output logic s_axi_awready,
    input wire logic [31:0] s_axi_wdata,
    input wire logic [3:0] s_axi_wstrb,
    input wire logic s_axi_wvalid,
    output logic s_axi_wready,
    output logic [1:0] s_axi_bresp,
    output logic s_axi_bvalid,
    input wire logic s_axi_bready,
    input wire logic [11:0] s_axi_araddr,
    input wire logic s_axi_arvalid,
    output logic s_axi_arready,
    output logic [31:0] s_axi_rdata,
    output logic [1:0] s_axi_rresp,
    output logic s_axi_rvalid,
    input wire logic s_axi_rready,
    // Timer side, same clock
    input wire logic carrier_underflow,
    input wire logic carrier_run_flag,
    input wire logic [2:0] phase_oneshot,
    input wire logic phase1_reload_ctrl,
    input wire logic odd_phase_output,
    output logic phase_start,
    output logic use_secondary_reload,
    output logic carrier_load,
    output logic [15:0] carrier_load_value,
    output logic carrier_reload,
    output logic carrier_interrupt,
    // Pins
    input wire logic shutdown_n,
    output logic [5:0] pwm_out,
    output logic [5:0] pwm_oe
);
    import tpc_pkg::*;

    tpc_state_s s;
    tpc_state_s n;

    ////////////////////////////////////////////////////////////////////////
    // Handshakes are combinational; one write and one read in flight

    assign s_axi_awready = !s.aw_held && !s.b_valid;
    assign s_axi_wready = !s.w_held && !s.b_valid;
    assign s_axi_arready = !s.r_valid;
    assign s_axi_bvalid = s.b_valid;
    assign s_axi_bresp = s.b_resp;
    assign s_axi_rvalid = s.r_valid;
    assign s_axi_rdata = s.r_data;
    assign s_axi_rresp = s.r_resp;

    // Registered side outputs
    assign phase_start = s.phase_start;
    assign carrier_load = s.carrier_load;
    assign carrier_load_value = s.carrier;
    assign carrier_reload = s.carrier_reload;
    assign carrier_interrupt = s.carrier_irq;
    assign use_secondary_reload = s.ctrl_one[`TPC_C1_PHASE_MODE];
    assign pwm_out = s.pin;
    // Enable low floats every phase pin
    assign pwm_oe = {6{s.ctrl_zero[`TPC_C0_OUT_EN]}};

    ////////////////////////////////////////////////////////////////////////
    // Next-state logic

    always_comb
    begin
        logic do_wr;
        logic [9:0] widx;
        logic [9:0] ridx;
        logic lane0;
        logic saw;
        logic sw_trig;
        logic car_wr;
        logic stop_wr;
        logic xfer;
        logic copy;
        logic pat_wr;
        logic dt_tick;
        logic dec_ev;
        logic first_short;
        logic [1:0] cond;
        logic [5:0] raw;
        logic [2:0] fall;
        logic [2:0] trig;
        logic [7:0] rbyte;
        logic rhit;
        do_wr = 1'b0;
        widx = 10'h000;
        ridx = 10'h000;
        lane0 = 1'b0;
        saw = 1'b0;
        sw_trig = 1'b0;
        car_wr = 1'b0;
        stop_wr = 1'b0;
        xfer = 1'b0;
        copy = 1'b0;
        pat_wr = 1'b0;
        dt_tick = 1'b0;
        dec_ev = 1'b0;
        first_short = 1'b0;
        cond = 2'b00;
        raw = 6'h00;
        fall = 3'b000;
        trig = 3'b000;
        rbyte = 8'h00;
        rhit = 1'b1;
        n = s;
        n.carrier_load = 1'b0;

        // Catch address and data in either order
        if (s_axi_awvalid && s_axi_awready)
        begin
            n.aw_held = 1'b1;
            n.aw_addr = s_axi_awaddr;
        end
        if (s_axi_wvalid && s_axi_wready)
        begin
            n.w_held = 1'b1;
            n.w_data = s_axi_wdata;
            n.w_strb = s_axi_wstrb;
        end
        if (s.b_valid && s_axi_bready)
            n.b_valid = 1'b0;

        do_wr = s.aw_held && s.w_held && !s.b_valid;
        widx = s.aw_addr[11:2];
        lane0 = s.w_strb[0];
        saw = s.ctrl_zero[`TPC_C0_MOD_SEL];

        // Register writes take effect when both halves are held
        if (do_wr)
        begin
            n.aw_held = 1'b0;
            n.w_held = 1'b0;
            n.b_valid = 1'b1;
            n.b_resp = `TPC_RESP_OKAY;
            unique case (widx)
                `TPC_IDX_CTRL_ZERO:
                    if (lane0)
                    begin
                        n.ctrl_zero = s.w_data[7:0] & `TPC_C0_WMASK;
                        sw_trig = s.w_data[`TPC_C0_SW_TRIG];
                    end
                `TPC_IDX_CTRL_ONE:
                    if (lane0)
                        n.ctrl_one = s.w_data[7:0] & `TPC_C1_WMASK;
                `TPC_IDX_PAT_ZERO:
                    if (lane0)
                    begin
                        n.pat_zero = s.w_data[5:0];
                        pat_wr = 1'b1;
                    end
                `TPC_IDX_PAT_ONE:
                    if (lane0)
                    begin
                        n.pat_one = s.w_data[5:0];
                        pat_wr = 1'b1;
                    end
                `TPC_IDX_DEADTIME:
                    if (lane0)
                        n.deadtime_reload = s.w_data[7:0];
                `TPC_IDX_DECIM:
                    if (lane0)
                    begin
                        cond = s.ctrl_zero[`TPC_C0_COND_HIGH:`TPC_C0_COND_LOW];
                        first_short = s.ctrl_one[`TPC_C1_PHASE_MODE] &&
                            (cond == 2'b11);
                        n.decim_value = s.w_data[7:0];
                        // First interrupt one underflow early
                        n.decim_count = first_short ?
                            s.w_data[7:0] - 8'h01 : s.w_data[7:0];
                    end
                `TPC_IDX_CARRIER:
                begin
                    if (s.w_strb[0])
                        n.carrier[7:0] = s.w_data[7:0];
                    if (s.w_strb[1])
                        n.carrier[15:8] = s.w_data[15:8];
                    car_wr = |s.w_strb[1:0];
                end
                `TPC_IDX_SPECIAL:
                    if (lane0)
                        n.special = s.w_data[7:0] & `TPC_SM_WMASK;
                default:
                    n.b_resp = `TPC_RESP_SLVERR;
            endcase
        end
        n.carrier_load = car_wr;

        // Transfer trigger and phase-timer start
        stop_wr = car_wr && !carrier_run_flag &&
            s.ctrl_one[`TPC_C1_START_SEL];
        xfer = carrier_underflow || sw_trig || stop_wr;
        n.phase_start = carrier_underflow || stop_wr;

        // Triangular copies once per write, sawtooth every trigger
        copy = xfer && (saw || s.dirty);
        n.dirty = (s.dirty && !xfer) || pat_wr;
        if (copy)
        begin
            n.shift_zero = s.pat_zero;
            n.shift_one = s.pat_one;
        end

        // Per phase: buffer select, dead-time trigger and counter
        dt_tick = s.ctrl_one[`TPC_C1_DT_CLK] ? s.dt_div : 1'b1;
        n.dt_div = !s.dt_div;
        for (int p = 0; p < 3; p++)
        begin
            raw[2*p +: 2] = s.use_second[p] ? s.shift_one[2*p +: 2] :
                s.shift_zero[2*p +: 2];
            fall[p] = s.oneshot_d[p] && !phase_oneshot[p];
            // Copy restarts the phase on buffer zero
            n.use_second[p] = copy ? 1'b0 :
                (s.use_second[p] || fall[p]);
            if (s.ctrl_one[`TPC_C1_DT_TRIG])
                trig[p] = |(raw[2*p +: 2] & ~s.raw_d[2*p +: 2]);
            else
                trig[p] = fall[p] || (saw && xfer);
            if (trig[p])
                n.dt_count[p] = s.deadtime_reload;
            else if (dt_tick && s.dt_count[p] != 8'h00)
                n.dt_count[p] = s.dt_count[p] - 8'h01;
            // Turn-off is immediate, turn-on waits for dead time
            for (int b = 2*p; b < 2*p + 2; b++)
            begin
                if (raw[b])
                    n.phase_int[b] = 1'b1;
                else if (s.ctrl_one[`TPC_C1_DT_DIS])
                    n.phase_int[b] = 1'b0;
                else if (!s.phase_int[b])
                    n.phase_int[b] = 1'b0;
                else
                    n.phase_int[b] = trig[p] ||
                        (s.dt_count[p] != 8'h00);
            end
        end
        n.oneshot_d = phase_oneshot;
        n.raw_d = raw;

        // Internal 0 means active
        n.pin = s.ctrl_one[`TPC_C1_ACT_LVL] ?
            ~n.phase_int : n.phase_int;

        // Interrupt decimation
        cond = s.ctrl_zero[`TPC_C0_COND_HIGH:`TPC_C0_COND_LOW];
        if (!s.ctrl_one[`TPC_C1_PHASE_MODE])
            dec_ev = carrier_underflow;
        else if (cond == 2'b11)
            dec_ev = carrier_underflow;
        else if (cond[1])
            dec_ev = carrier_underflow && phase1_reload_ctrl;
        else
            dec_ev = carrier_underflow && !phase1_reload_ctrl;
        n.carrier_irq = 1'b0;
        // A write in the same cycle takes precedence
        if (dec_ev && !(do_wr && widx == `TPC_IDX_DECIM && lane0))
        begin
            if (s.decim_count <= 8'h01)
            begin
                n.carrier_irq = 1'b1;
                n.decim_count = s.decim_value;
            end
            else
                n.decim_count = s.decim_count - 8'h01;
        end

        // Carrier reload source
        n.carrier_reload = s.special[`TPC_SM_RELOAD_TIMING] ?
            odd_phase_output : carrier_underflow;

        // Shutdown sync; first stage feeds only the second
        n.sd_meta = shutdown_n;
        n.sd_sync = s.sd_meta;
        if (s.special[`TPC_SM_CUTOFF_EN] && !s.sd_sync)
            n.ctrl_zero[`TPC_C0_OUT_EN] = 1'b0;

        // Read path
        if (s.r_valid && s_axi_rready)
            n.r_valid = 1'b0;
        if (s_axi_arvalid && s_axi_arready)
        begin
            ridx = s_axi_araddr[11:2];
            unique case (ridx)
                `TPC_IDX_CTRL_ZERO:
                    rbyte = s.ctrl_zero; // software trigger reads 0
                `TPC_IDX_CTRL_ONE:
                begin
                    rbyte = s.ctrl_one;
                    rbyte[`TPC_C1_SLOPE] = phase1_reload_ctrl;
                end
                `TPC_IDX_PAT_ZERO:
                    rbyte = {2'b00, s.shift_zero};
                `TPC_IDX_PAT_ONE:
                    rbyte = {2'b00, s.shift_one};
                `TPC_IDX_DEADTIME:
                    rbyte = s.deadtime_reload;
                `TPC_IDX_DECIM:
                    rbyte = s.decim_count;
                `TPC_IDX_CARRIER:
                    rbyte = 8'h00;
                `TPC_IDX_SPECIAL:
                    rbyte = s.special;
                default:
                    rhit = 1'b0;
            endcase
            n.r_valid = 1'b1;
            n.r_data = (ridx == `TPC_IDX_CARRIER) ?
                {16'h0000, s.carrier} : {24'h000000, rbyte};
            n.r_resp = rhit ? `TPC_RESP_OKAY : `TPC_RESP_SLVERR;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // State register

    always_ff @(posedge clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            s <= '0;
            s.ctrl_zero <= `TPC_RST_REG8;
            s.ctrl_one <= `TPC_RST_REG8;
            s.special <= `TPC_RST_REG8;
            s.carrier <= `TPC_RST_CAR;
            s.pat_zero <= `TPC_RST_PAT;
            s.pat_one <= `TPC_RST_PAT;
            s.shift_zero <= `TPC_RST_PAT;
            s.shift_one <= `TPC_RST_PAT;
            s.raw_d <= `TPC_RST_PAT;
            s.phase_int <= `TPC_RST_PAT;
            s.pin <= `TPC_RST_PAT;
            s.sd_meta <= 1'b1;
            s.sd_sync <= 1'b1;
        end
        else
            s <= n;
    end

endmodule
`default_nettype wire

// *** verif/tpc_gate_model.sv ***
// Gate-driver model standing on the six phase pins.
// Assumes the bench tells it which pin level means on.
`timescale 1ns/10ps
`default_nettype none
module tpc_gate_model (
    input wire logic clk,
    input wire logic [5:0] pwm_out,
    input wire logic [5:0] pwm_oe,
    input wire logic active_high,
    output logic [5:0] gate_on
);
    logic [5:0] last = 6'h00;
    logic [5:0] level;

    // A floating pin shows the inverse of its last driven level
    assign level = (pwm_oe & pwm_out) | (~pwm_oe & ~last);
    always @(posedge clk)
        last <= (pwm_oe & pwm_out) | (~pwm_oe & last);

    // Driver input decodes the pin by the programmed active level
    assign gate_on = active_high ? level : ~level;
endmodule
`default_nettype wire

// *** verif/tpc_pwm_assertions.sv ***
// Concurrent checks on the PWM configuration block's ports.
// Assumes it is bound onto tpc_pwm and sees only its ports.
`timescale 1ns/10ps
`default_nettype none
module tpc_pwm_assertions (
    input wire logic clk,
    input wire logic rst_n,
    input wire logic s_axi_awvalid,
    input wire logic s_axi_awready,
    input wire logic s_axi_wvalid,
    input wire logic s_axi_wready,
    input wire logic [1:0] s_axi_bresp,
    input wire logic s_axi_bvalid,
    input wire logic s_axi_bready,
    input wire logic s_axi_arvalid,
    input wire logic s_axi_arready,
    input wire logic [31:0] s_axi_rdata,
    input wire logic s_axi_rvalid,
    input wire logic s_axi_rready,
    input wire logic use_secondary_reload,
    input wire logic [5:0] pwm_oe
);
    default clocking @(posedge clk); endclocking
    default disable iff (!rst_n);
    ////////////////////////////////////////////////////////////////////////
    // Read answers come one cycle after the request, write answers two; both then stand
    // Both halves are held for one cycle before the write lands
    a_write_answer: assert property (s_axi_awvalid && s_axi_awready &&
        s_axi_wvalid && s_axi_wready |-> ##2 s_axi_bvalid)
        else $error("write response late");
    a_read_answer: assert property (s_axi_arvalid && s_axi_arready
        |=> s_axi_rvalid)
        else $error("read response late");
    a_bresp_hold: assert property (s_axi_bvalid && !s_axi_bready
        |=> s_axi_bvalid && $stable(s_axi_bresp))
        else $error("write response dropped");
    a_rdata_hold: assert property (s_axi_rvalid && !s_axi_rready
        |=> s_axi_rvalid && $stable(s_axi_rdata))
        else $error("read data dropped");
    a_busy_refuse: assert property (s_axi_bvalid
        |-> !s_axi_awready && !s_axi_wready)
        else $error("write taken while answering");
    ////////////////////////////////////////////////////////////////////////
    // Reads stay 16 bits, enables move together; phase mode and enable rise only move through writes
    a_read_width: assert property (s_axi_rvalid |-> s_axi_rdata[31:16] == 16'h0000)
        else $error("read upper bits set");
    a_mode_by_write: assert property ($changed(use_secondary_reload)
        |-> s_axi_bvalid || $past(s_axi_bvalid) || $past(s_axi_bvalid, 2))
        else $error("phase mode moved without write");
    a_oe_uniform: assert property (pwm_oe == 6'h00 || pwm_oe == 6'h3f)
        else $error("pin enables split");
    // Enable and write response rise on the same edge
    a_oe_rise: assert property ($rose(pwm_oe[0])
        |-> s_axi_bvalid)
        else $error("pins enabled without write");
endmodule

bind tpc_pwm tpc_pwm_assertions u_chk (.*);
`default_nettype wire

// *** verif/tb_top.sv ***
// Self-checking bench for the PWM configuration block.
// Assumes the gate model and bound checker are compiled alongside.
`timescale 1ns/10ps
`default_nettype none
`include "tpc_cfg.svh"
module tb_top;
    logic clk = 0, rst_n = 0, ah = 0;
    logic [11:0] s_axi_awaddr = 0, s_axi_araddr = 0;
    logic s_axi_awvalid = 0, s_axi_wvalid = 0, s_axi_bready = 0;
    logic s_axi_arvalid = 0, s_axi_rready = 0;
    logic [31:0] s_axi_wdata = 0, s_axi_rdata, rdat, seed = 32'hfdb9;
    logic [3:0] s_axi_wstrb = 0;
    logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready;
    logic s_axi_rvalid, phase_start, use_secondary_reload, carrier_load;
    logic carrier_reload, carrier_interrupt;
    logic [1:0] s_axi_bresp, s_axi_rresp, resp;
    logic carrier_underflow = 0, carrier_run_flag = 0, shutdown_n = 1;
    logic phase1_reload_ctrl = 0, odd_phase_output = 0;
    logic [2:0] phase_oneshot = 0;
    logic [15:0] carrier_load_value;
    logic [5:0] pwm_out, pwm_oe, gate_on, pa, pb, pc, cur;
    int fails = 0, tests_run = 0, n_st = 0, n_irq = 0, n_rel = 0, n_ld = 0;
    int b0, b1, b2, n, k;

    tpc_pwm dut (.*);
    tpc_gate_model u_gate (.clk(clk), .pwm_out(pwm_out), .pwm_oe(pwm_oe),
        .active_high(ah), .gate_on(gate_on));

    // Clock and pulse counters, sampled mid-cycle to stay off the edge
    always #20 clk = ~clk;
    always @(negedge clk)
    begin
        if (phase_start === 1'b1) n_st++;
        if (carrier_interrupt === 1'b1) n_irq++;
        if (carrier_reload === 1'b1) n_rel++;
        if (carrier_load === 1'b1) n_ld++;
    end
    ////////////////////////////////////////////////////////////////////////
    function automatic logic [31:0] xorshift();
        seed ^= seed << 13;
        seed ^= seed >> 17;
        seed ^= seed << 5;
        return seed;
    endfunction

    // Interrupts expected from k events with decimation n
    function automatic int exp_irq(int m, int n, int k);
        int c, r;
        c = 0;
        r = m ? n - 1 : n;
        for (int i = 0; i < k; i++)
        begin
            r--;
            if (r == 0)
            begin
                c++;
                r = n;
            end
        end
        return c;
    endfunction

    task automatic chk(input logic [31:0] s, input logic [31:0] e);
        tests_run++;
        if (s !== e)
        begin
            fails++;
            $display("[ERR] t=%0t seen=%h exp=%h", $time, s, e);
        end
    endtask

    task automatic conclude();
        if (fails == 0 && tests_run > 0)
            $display("Run complete: PASS");
        else
            $display("Run complete: FAIL");
        $finish;
    endtask
    ////////////////////////////////////////////////////////////////////////
    // Bus master: ready sampled mid-cycle, response ready raised late
    task automatic wr(input logic [9:0] i, input logic [31:0] d);
        logic a, w, b;
        int c;
        c = 0;
        b = 0;
        @(posedge clk);
        s_axi_awaddr <= {i, 2'b00};
        s_axi_awvalid <= 1'b1;
        s_axi_wdata <= d;
        s_axi_wstrb <= 4'hf;
        s_axi_wvalid <= 1'b1;
        while (!b)
        begin
            @(negedge clk);
            a = s_axi_awvalid && s_axi_awready;
            w = s_axi_wvalid && s_axi_wready;
            b = s_axi_bvalid && s_axi_bready;
            resp = s_axi_bresp;
            @(posedge clk);
            c++;
            if (a) s_axi_awvalid <= 1'b0;
            if (w) s_axi_wvalid <= 1'b0;
            if (c == 2) s_axi_bready <= 1'b1;
            if (b) s_axi_bready <= 1'b0;
        end
    endtask

    task automatic rd(input logic [9:0] i);
        logic a, r;
        int c;
        c = 0;
        r = 0;
        @(posedge clk);
        s_axi_araddr <= {i, 2'b00};
        s_axi_arvalid <= 1'b1;
        while (!r)
        begin
            @(negedge clk);
            a = s_axi_arvalid && s_axi_arready;
            r = s_axi_rvalid && s_axi_rready;
            rdat = s_axi_rdata;
            resp = s_axi_rresp;
            @(posedge clk);
            c++;
            if (a) s_axi_arvalid <= 1'b0;
            if (c == 2) s_axi_rready <= 1'b1;
            if (r) s_axi_rready <= 1'b0;
        end
    endtask

    // Timer-side pulses: carrier underflow and a phase U one-shot
    task automatic uf();
        @(posedge clk) carrier_underflow <= 1'b1;
        @(posedge clk) carrier_underflow <= 1'b0;
        repeat (4) @(posedge clk);
    endtask

    task automatic shot();
        @(posedge clk) phase_oneshot <= 3'b001;
        repeat (3) @(posedge clk);
        phase_oneshot <= 3'b000;
        repeat (5) @(posedge clk);
    endtask
    ////////////////////////////////////////////////////////////////////////
    // Watchdog: the sequence needs far fewer than 50000 cycles
    initial
    begin
        #2000000;
        fails++;
        conclude();
    end

    initial
    begin
        repeat (2) @(posedge clk);
        rst_n <= 1'b1;
        rd(10'h309); chk(rdat, 32'h00);
        rd(10'h33e); chk(rdat, 32'h00);
        rd(10'h000); chk(resp, `TPC_RESP_SLVERR);
        // Dead time off, active low; patterns wait for a transfer
        wr(10'h309, 32'h20);
        pa = 6'(xorshift());
        pb = 6'(xorshift());
        wr(10'h30a, pa);
        wr(10'h30b, pb);
        rd(10'h30a); chk(rdat, 32'h3f);
        wr(10'h308, 32'h88);
        rd(10'h308); chk(rdat, 32'h08);
        rd(10'h30a); chk(rdat, pa);
        rd(10'h30b); chk(rdat, pb);
        repeat (4) @(posedge clk);
        cur = pa;
        chk(pwm_out, cur);
        cur = ~pa;
        chk(gate_on, cur);
        shot();
        cur = {pa[5:2], pb[1:0]};
        chk(pwm_out, cur);
        ah <= 1'b1;
        wr(10'h309, 32'h30);
        repeat (4) @(posedge clk);
        cur = ~{pa[5:2], pb[1:0]};
        chk(pwm_out, cur);
        // Triangular: rewrite waits for the next underflow
        pc = 6'(xorshift());
        wr(10'h30a, pc);
        rd(10'h30a); chk(rdat, pa);
        uf();
        rd(10'h30a); chk(rdat, pc);
        cur = ~pc;
        chk(pwm_out[1:0], cur[1:0]);
        wr(10'h308, 32'h48);
        shot();
        uf();
        chk(pwm_out, cur);
        // Stopped carrier write starts phases only with start select
        for (int s = 0; s < 2; s++)
        begin
            wr(10'h309, 32'h30 | s);
            b0 = n_st;
            b1 = n_ld;
            wr(10'h334, 32'h1234 + s);
            repeat (4) @(posedge clk);
            chk(n_st - b0, s);
            chk(n_ld - b1, 1);
            chk(carrier_load_value, 32'h1234 + s);
        end
        @(posedge clk) phase1_reload_ctrl <= 1'b1;
        rd(10'h309); chk(rdat, 32'h39);
        // Decimation in mode 0 and in mode 1 with condition 11b
        for (int m = 0; m < 2; m++)
        begin
            wr(10'h309, m ? 32'h32 : 32'h30);
            wr(10'h308, m ? 32'h0b : 32'h08);
            n = 2 + (xorshift() % 4);
            k = 2 * n + 2;
            wr(10'h30d, n);
            b0 = n_irq;
            b1 = n_st;
            b2 = n_rel;
            repeat (k) uf();
            chk(n_irq - b0, exp_irq(m, n, k));
            chk(n_st - b1, k);
            chk(n_rel - b2, k);
            chk(use_secondary_reload, m);
        end
        // Dead time holds back U turn-on; the halved clock doubles it
        wr(10'h30c, 32'h08);
        for (int dc = 0; dc < 2; dc++)
        begin
            wr(10'h309, 32'h10 | (dc << 2));
            wr(10'h30a, 32'h3f);
            wr(10'h30b, 32'h3e);
            uf();
            shot();
            repeat (8 * dc) @(posedge clk);
            chk(pwm_out[0], 1'b0);
            repeat (8) @(posedge clk);
            chk(pwm_out[0], 1'b1);
        end
        // Reload timing 1: only odd phase outputs reload the carrier
        wr(10'h309, 32'h32);
        wr(10'h33e, 32'h01);
        b2 = n_rel;
        uf();
        @(posedge clk) odd_phase_output <= 1'b1;
        @(posedge clk) odd_phase_output <= 1'b0;
        repeat (3) @(posedge clk);
        chk(n_rel - b2, 1);
        // Shutdown is ignored until cutoff is enabled
        @(posedge clk) shutdown_n <= 1'b0;
        repeat (6) @(posedge clk);
        chk(pwm_oe, 32'h3f);
        wr(10'h33e, 32'h02);
        repeat (6) @(posedge clk);
        chk(pwm_oe, 32'h00);
        rd(10'h308); chk(rdat, 32'h03);
        rd(10'h33e); chk(rdat, 32'h02);
        wr(10'h001, 32'hff); chk(resp, `TPC_RESP_SLVERR);
        conclude();
    end
endmodule
`default_nettype wire
